// [rtl/page_walk_pkg.sv]
package page_walk_pkg;

  // ------------------------------------------------------------------
  // Entry field positions
  // ------------------------------------------------------------------
  localparam int ENT_VALID = 0;
  localparam int ENT_WRITE_OK = 1;
  localparam int ENT_USER_OK = 2;
  localparam int ENT_TOUCHED = 5;
  localparam int ENT_WRITTEN = 6;
  localparam int ENT_OS_LO = 9;
  localparam int ENT_OS_HI = 11;

  // ------------------------------------------------------------------
  // Address split and sizes
  // ------------------------------------------------------------------
  localparam int PAGE_BYTES = 4096;
  localparam int PAGE_SHIFT = 12;
  localparam int INDEX_BITS = 10;
  localparam int FRAME_BITS = 20;
  localparam int DIR_IDX_LO = 22;
  localparam int TBL_IDX_LO = 12;
  localparam logic [1:0] ENTRY_WORD_PAD = 2'h0;
  localparam logic [11:0] PAGE_ZERO = 12'h000;

  // ------------------------------------------------------------------
  // Control register selects and reset values
  // ------------------------------------------------------------------
  localparam logic CR_SEL_FAULT_ADDR = 1'h0;
  localparam logic CR_SEL_DIR_BASE = 1'h1;
  localparam logic [31:0] FAULT_ADDR_RESET = 32'h0000_0000;
  localparam logic [19:0] DIR_BASE_RESET = 20'h0_0000;

  // ------------------------------------------------------------------
  // Page fault error code bits
  // ------------------------------------------------------------------
  localparam int ERR_PROT = 0;
  localparam int ERR_WRITE = 1;
  localparam int ERR_USER = 2;
  localparam int PAGE_FAULT_VECTOR = 14;

  // Walker states.
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_DIR_RD,
    ST_DIR_CHK,
    ST_DIR_WR,
    ST_TBL_RD,
    ST_TBL_CHK,
    ST_TBL_WR
  } walk_state_t;

endpackage : page_walk_pkg

// [rtl/entry_check_if.sv]
`timescale 1ns/10ps
interface entry_check_if;
  logic [31:0] entry;
  logic isTable;
  logic write;
  logic user;
  logic dirUser;
  logic dirWrite;
  logic present;
  logic allowed;
  logic needUpdate;
  logic [31:0] newEntry;

  modport walker
  (
    output entry, isTable, write, user, dirUser, dirWrite,
    input present, allowed, needUpdate, newEntry
  );

  modport judge
  (
    input entry, isTable, write, user, dirUser, dirWrite,
    output present, allowed, needUpdate, newEntry
  );
endinterface : entry_check_if

// [rtl/entry_check.sv]
`timescale 1ns/10ps
module entry_check
  import page_walk_pkg::*;
(
  // Entry under test and access kind.
  entry_check_if.judge chk
);

  logic effUser;
  logic effWrite;

  // Effective rights are the weaker of directory and table rights.
  assign effUser = chk.dirUser & chk.entry[ENT_USER_OK];
  assign effWrite = chk.dirWrite & chk.entry[ENT_WRITE_OK];

  // Only the valid bit is looked at until the entry is known valid.
  assign chk.present = chk.entry[ENT_VALID];

  // Supervisor accesses pass; at the table level user ones need user rights, and write rights for a write.
  always_comb
  begin
    chk.allowed = 1'b1;
    if (chk.isTable && chk.user)
    begin
      chk.allowed = effUser & (effWrite | ~chk.write);
    end
  end

  // Touched is set on both levels, written only on a table write; the
  // operating system bits pass through unchanged.
  always_comb
  begin
    chk.newEntry = chk.entry;
    chk.newEntry[ENT_TOUCHED] = 1'b1;
    if (chk.isTable && chk.write)
    begin
      chk.newEntry[ENT_WRITTEN] = 1'b1;
    end
    chk.needUpdate = (chk.newEntry != chk.entry);
  end

endmodule : entry_check

// [rtl/two_level_page_translation.sv]
`timescale 1ns/10ps
// Behaviour
// - Translate through a page directory then a page table, all 4K.
// - Each page fault writes the whole linear address to the fault register.
// - Directory base low twelve bits always read as zero.
// - Writing directory base, or a changing task switch, flushes cached entries.
// - Linear bits 31..22 index the directory from its base.
// - Linear bits 21..12 index the table named by the directory entry.
// - Physical address is table frame on top of linear bits 11..0.
// - Bit 0 set makes an entry usable; clear means never used.
// - With bit 0 clear, the other 31 bits are ignored.
// - Touched bit 5 set in both entries before any access.
// - Written bit 6 set in the table entry before any write.
// - Flag updates use a locked read-modify-write on the bus.
// - Entry bits 11..9 are neither interpreted nor changed.
// - Bit 2 is the user flag, bit 1 the write flag.
// - An invalid directory or table entry faults and stops the access.
// - Rights are the weaker of both levels; user level is checked.
// - Error code bit 0 protection, bit 1 write, bit 2 user.
module two_level_page_translation
  import page_walk_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // Translation request.
  input wire logic reqValid,
  input wire logic [31:0] reqLinAddr,
  input wire logic reqWrite,
  input wire logic reqUser,
  output logic reqReady,
  // Translation answer.
  output logic respValid,
  output logic [31:0] respPhysAddr,
  output logic respFault,
  output logic [15:0] respErrCode,
  // Control register access.
  input wire logic crWrite,
  input wire logic crSel,
  input wire logic [31:0] crWdata,
  output logic [31:0] crRdata,
  // Task switch loading a new directory base.
  input wire logic taskSwitch,
  input wire logic [31:0] taskDirBase,
  // Memory bus for table entries.
  output logic memReq,
  output logic [31:0] memAddr,
  output logic memWrite,
  output logic [31:0] memWdata,
  output logic memLock,
  input wire logic memAck,
  input wire logic [31:0] memRdata
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed
  {
    walk_state_t st;
    logic [31:0] lin;
    logic write;
    logic user;
    logic [31:0] entry;
    logic dirUser;
    logic dirWrite;
    logic [31:0] faultAddr;
    logic [19:0] dirBase;
    logic tlbValid;
    logic [19:0] tlbTag;
    logic [19:0] tlbFrame;
    logic tlbUser;
    logic tlbWr;
    logic tlbDirty;
    logic ready;
    logic respValid;
    logic [31:0] respPhys;
    logic respFault;
    logic [15:0] respErr;
    logic [31:0] crRdata;
    logic memReq;
    logic [31:0] memAddr;
    logic memWrite;
    logic [31:0] memWdata;
    logic memLock;
  } walk_regs_t;

  walk_regs_t s;
  walk_regs_t next_s;
  logic hit;
  logic hitOk;

  entry_check_if chkBus ();

  entry_check checkUnit
  (
    .chk(chkBus.judge)
  );

  // Feed the captured entry and access kind to the entry checker.
  always_comb
  begin
    chkBus.entry = s.entry;
    chkBus.isTable = (s.st == ST_TBL_CHK);
    chkBus.write = s.write;
    chkBus.user = s.user;
    chkBus.dirUser = s.dirUser;
    chkBus.dirWrite = s.dirWrite;
  end

  // A cached entry serves a request only when no flag update is due.
  assign hit = s.tlbValid && (s.tlbTag == reqLinAddr[31:PAGE_SHIFT]);
  assign hitOk = (!reqWrite || s.tlbDirty) &&
                 (!reqUser || (s.tlbUser && (s.tlbWr || !reqWrite)));

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.respValid = 1'b0;
    next_s.crRdata = (crSel == CR_SEL_DIR_BASE) ?
                     {s.dirBase, PAGE_ZERO} : s.faultAddr;
    if (crWrite && crSel == CR_SEL_FAULT_ADDR)
    begin
      next_s.faultAddr = crWdata;
    end
    case (s.st)
      ST_IDLE:
      begin
        if (reqValid)
        begin
          next_s.ready = 1'b0;
          next_s.lin = reqLinAddr;
          next_s.write = reqWrite;
          next_s.user = reqUser;
          if (hit && hitOk)
          begin
            next_s.respValid = 1'b1;
            next_s.respFault = 1'b0;
            next_s.respPhys = {s.tlbFrame, reqLinAddr[11:0]};
            next_s.ready = 1'b1;
          end
          else
          begin
            // Directory entry word from base and top index.
            next_s.memReq = 1'b1;
            next_s.memWrite = 1'b0;
            next_s.memLock = 1'b1;
            next_s.memAddr = {s.dirBase, reqLinAddr[31:DIR_IDX_LO],
                              ENTRY_WORD_PAD};
            next_s.st = ST_DIR_RD;
          end
        end
      end
      ST_DIR_RD, ST_TBL_RD:
      begin
        if (memAck)
        begin
          next_s.memReq = 1'b0;
          next_s.entry = memRdata;
          next_s.st = (s.st == ST_DIR_RD) ? ST_DIR_CHK : ST_TBL_CHK;
        end
      end
      ST_DIR_CHK, ST_TBL_CHK:
      begin
        if (!chkBus.present || !chkBus.allowed)
        begin
          // Fault: no flag update, no access; address captured.
          next_s.memLock = 1'b0;
          next_s.respValid = 1'b1;
          next_s.respFault = 1'b1;
          next_s.respErr = '0;
          next_s.respErr[ERR_PROT] = chkBus.present;
          next_s.respErr[ERR_WRITE] = s.write;
          next_s.respErr[ERR_USER] = s.user;
          next_s.faultAddr = s.lin;
          next_s.ready = 1'b1;
          next_s.st = ST_IDLE;
        end
        else
        begin
          if (s.st == ST_DIR_CHK)
          begin
            next_s.dirUser = s.entry[ENT_USER_OK];
            next_s.dirWrite = s.entry[ENT_WRITE_OK];
          end
          else
          begin
            // Fill the cache with the table frame and weaker rights.
            next_s.tlbValid = 1'b1;
            next_s.tlbTag = s.lin[31:PAGE_SHIFT];
            next_s.tlbFrame = s.entry[31:PAGE_SHIFT];
            next_s.tlbUser = s.dirUser & s.entry[ENT_USER_OK];
            next_s.tlbWr = s.dirWrite & s.entry[ENT_WRITE_OK];
            next_s.tlbDirty = chkBus.newEntry[ENT_WRITTEN];
          end
          if (chkBus.needUpdate)
          begin
            // Write back under the lock held since the read.
            next_s.memReq = 1'b1;
            next_s.memWrite = 1'b1;
            next_s.memWdata = chkBus.newEntry;
            next_s.st = (s.st == ST_DIR_CHK) ? ST_DIR_WR : ST_TBL_WR;
          end
          else if (s.st == ST_DIR_CHK)
          begin
            // The table read takes the lock again for its own update.
            next_s.memReq = 1'b1;
            next_s.memWrite = 1'b0;
            next_s.memLock = 1'b1;
            next_s.memAddr = {s.entry[31:PAGE_SHIFT],
                              s.lin[21:TBL_IDX_LO], ENTRY_WORD_PAD};
            next_s.st = ST_TBL_RD;
          end
          else
          begin
            next_s.memLock = 1'b0;
            next_s.respValid = 1'b1;
            next_s.respFault = 1'b0;
            next_s.respPhys = {s.entry[31:PAGE_SHIFT], s.lin[11:0]};
            next_s.ready = 1'b1;
            next_s.st = ST_IDLE;
          end
        end
      end
      ST_DIR_WR:
      begin
        if (memAck)
        begin
          // Lock drops for one cycle between the two levels.
          next_s.memReq = 1'b0;
          next_s.memWrite = 1'b0;
          next_s.memLock = 1'b0;
          next_s.entry[ENT_TOUCHED] = 1'b1;
          next_s.st = ST_DIR_CHK;
        end
      end
      ST_TBL_WR:
      begin
        if (memAck)
        begin
          next_s.memReq = 1'b0;
          next_s.memWrite = 1'b0;
          next_s.memLock = 1'b0;
          next_s.respValid = 1'b1;
          next_s.respFault = 1'b0;
          next_s.respPhys = {s.entry[31:PAGE_SHIFT], s.lin[11:0]};
          next_s.ready = 1'b1;
          next_s.st = ST_IDLE;
        end
      end
      default:
      begin
        next_s.st = ST_IDLE;
        next_s.ready = 1'b1;
      end
    endcase
    // Base reloads come last so a flush beats a same-cycle fill.
    if (crWrite && crSel == CR_SEL_DIR_BASE)
    begin
      next_s.dirBase = crWdata[31:PAGE_SHIFT];
      next_s.tlbValid = 1'b0;
    end
    else if (taskSwitch && taskDirBase[31:PAGE_SHIFT] != s.dirBase)
    begin
      next_s.dirBase = taskDirBase[31:PAGE_SHIFT];
      next_s.tlbValid = 1'b0;
    end
  end

  // Register the whole state.
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.st <= ST_IDLE;
      s.ready <= 1'b1;
      s.faultAddr <= FAULT_ADDR_RESET;
      s.dirBase <= DIR_BASE_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state flops.
  assign reqReady = s.ready;
  assign respValid = s.respValid;
  assign respPhysAddr = s.respPhys;
  assign respFault = s.respFault;
  assign respErrCode = s.respErr;
  assign crRdata = s.crRdata;
  assign memReq = s.memReq;
  assign memAddr = s.memAddr;
  assign memWrite = s.memWrite;
  assign memWdata = s.memWdata;
  assign memLock = s.memLock;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence seqFaultOut;
    respValid ##0 respFault;
  endsequence

  sequence seqInvalidEntry;
    (s.st == ST_DIR_CHK || s.st == ST_TBL_CHK) && !s.entry[ENT_VALID];
  endsequence

  chk_base_low_zero: assert property (
    $past(crSel) == CR_SEL_DIR_BASE |-> crRdata[11:0] == PAGE_ZERO)
    else $error("base low bits not zero");
  chk_fault_addr_kept: assert property (
    seqFaultOut |-> s.faultAddr == s.lin)
    else $error("fault address not captured");
  chk_dir_index: assert property (
    memReq && s.st == ST_DIR_RD |->
    memAddr == {s.dirBase, s.lin[31:22], 2'h0})
    else $error("directory entry address wrong");
  chk_tbl_index: assert property (
    memReq && s.st == ST_TBL_RD |->
    memAddr[11:0] == {s.lin[21:12], 2'h0})
    else $error("table entry address wrong");
  chk_phys_low: assert property (
    respValid && !respFault |-> respPhysAddr[11:0] == s.lin[11:0])
    else $error("page offset lost");
  chk_invalid_faults: assert property (
    seqInvalidEntry |=> seqFaultOut ##0 !respErrCode[0])
    else $error("invalid entry used");
  chk_locked_update: assert property (
    memReq && memWrite |->
    memLock && memWdata[5] && memWdata[11:9] == s.entry[11:9])
    else $error("entry update not locked");
  chk_dirty_on_write: assert property (
    memReq && memWrite && s.st == ST_TBL_WR && s.write |-> memWdata[6])
    else $error("written flag missing");
  chk_base_flush: assert property (
    crWrite && crSel == CR_SEL_DIR_BASE |=> !s.tlbValid)
    else $error("cache not flushed");
  chk_write_done: assert property (
    s.st == ST_TBL_WR && memAck |=> respValid && !respFault ##1 !memLock)
    else $error("write end wrong");

endmodule : two_level_page_translation

// [verification/mem_model.sv]
`timescale 1ns/10ps
module mem_model
(
  // Clock.
  input wire logic clock,
  // Requests from the walker.
  input wire logic memReq,
  input wire logic [31:0] memAddr,
  input wire logic memWrite,
  input wire logic [31:0] memWdata,
  input wire logic memLock,
  // Answers to the walker.
  output logic memAck,
  output logic [31:0] memRdata
);
  // Word store and bus watch counters.
  logic [31:0] mem [int unsigned];
  logic [31:0] lastRd = 32'h0;
  logic [31:0] lastRdAddr = 32'h0;
  int waitLeft = 0;
  int seed = 32'h5A17C3E1;
  int badWrites = 0;
  int misaligned = 0;

  initial
  begin
    memAck = 1'b0;
    memRdata = 32'h0;
  end

  // Answers after a random wait; idle read data is never the last value.
  always @(posedge clock)
  begin
    logic ack;
    ack = 1'b0;
    if (memReq && !memAck)
    begin
      if (waitLeft > 0)
        waitLeft = waitLeft - 1;
      else
      begin
        waitLeft = $unsigned($random(seed)) % 4;
        ack = 1'b1;
        if (memAddr[1:0] != 2'h0)
          misaligned++;
        if (memWrite)
        begin
          mem[memAddr[31:2]] = memWdata;
          // Write-back must be locked and hit the word just read.
          if (!memLock || memAddr != lastRdAddr)
            badWrites++;
        end
        else
        begin
          lastRdAddr = memAddr;
          lastRd = mem.exists(memAddr[31:2]) ? mem[memAddr[31:2]] : 32'h0;
        end
      end
    end
    // Each output is driven once per edge.
    memAck <= ack;
    memRdata <= (ack && !memWrite) ? lastRd : ~lastRd;
  end
endmodule : mem_model

// [verification/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  import page_walk_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic reqValid = 1'b0, reqWrite = 1'b0, reqUser = 1'b0;
  logic [31:0] reqLinAddr = 32'h0, crWdata = 32'h0, taskDirBase = 32'h0;
  logic crWrite = 1'b0, crSel = 1'b0, taskSwitch = 1'b0;
  logic reqReady, respValid, respFault, memReq, memWrite, memLock, memAck;
  logic [15:0] respErrCode;
  logic [31:0] respPhysAddr, crRdata, memAddr, memWdata, memRdata;
  logic [31:0] base = 32'h0, v, d, t, lin, r;
  int seed = 32'hE3633BC3;
  int failures = 0;
  int checks_done = 0;

  two_level_page_translation u_two_level_page_translation (.clock(clock),
    .sys_rst(sys_rst), .reqValid(reqValid), .reqLinAddr(reqLinAddr),
    .reqWrite(reqWrite), .reqUser(reqUser), .reqReady(reqReady),
    .respValid(respValid), .respPhysAddr(respPhysAddr),
    .respFault(respFault), .respErrCode(respErrCode), .crWrite(crWrite),
    .crSel(crSel), .crWdata(crWdata), .crRdata(crRdata),
    .taskSwitch(taskSwitch), .taskDirBase(taskDirBase), .memReq(memReq),
    .memAddr(memAddr), .memWrite(memWrite), .memWdata(memWdata),
    .memLock(memLock), .memAck(memAck), .memRdata(memRdata));

  mem_model u_mem_model (.clock(clock), .memReq(memReq), .memAddr(memAddr),
    .memWrite(memWrite), .memWdata(memWdata), .memLock(memLock),
    .memAck(memAck), .memRdata(memRdata));

  // Clock of 100 ns.
  always #50 clock = ~clock;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] e, input logic [31:0] a);
    checks_done++;
    if (a !== e)
    begin
      failures++;
      $display("ERROR at %0t: expected %h got %h", $time, e, a);
    end
  endtask : check

  // Outcome: 0 done, 1 directory absent, 2 table absent, 3 rights.
  function automatic logic [1:0] outcome(input logic [31:0] de,
    input logic [31:0] te, input logic w, input logic u);
    if (!de[ENT_VALID])
      return 2'h1;
    if (!te[ENT_VALID])
      return 2'h2;
    if (u && !(de[2] && te[2] && (!w || (de[1] && te[1]))))
      return 2'h3;
    return 2'h0;
  endfunction : outcome

  task automatic read_cr(input logic sel, output logic [31:0] val);
    crSel = sel;
    @(negedge clock);
    @(negedge clock);
    val = crRdata;
  endtask : read_cr

  task automatic set_base(input logic [31:0] val);
    crWrite = 1'b1;
    crSel = CR_SEL_DIR_BASE;
    crWdata = val;
    @(negedge clock);
    crWrite = 1'b0;
    base = {val[31:12], 12'h000};
    read_cr(CR_SEL_DIR_BASE, v);
    check(base, v);
  endtask : set_base

  task automatic translate(input logic [31:0] a, input logic w,
    input logic u);
    int n;
    reqValid = 1'b1;
    reqLinAddr = a;
    reqWrite = w;
    reqUser = u;
    @(negedge clock);
    reqValid = 1'b0;
    for (n = 0; n < 300 && respValid !== 1'b1; n++)
      @(negedge clock);
    if (n == 300)
    begin
      failures++;
      $display("ERROR at %0t: expected %h got %h", $time, 1'b1, respValid);
      finish_test();
    end
  endtask : translate

  // Places both entries, walks, then checks answer and memory flags.
  task automatic run_walk(input logic [31:0] a, input logic [31:0] de,
    input logic [31:0] te, input logic w, input logic u);
    logic [31:0] da, ta;
    logic [1:0] k;
    da = {base[31:12], a[31:22], 2'h0};
    ta = {de[31:12], a[21:12], 2'h0};
    u_mem_model.mem[da[31:2]] = de;
    u_mem_model.mem[ta[31:2]] = te;
    k = outcome(de, te, w, u);
    translate(a, w, u);
    check({31'h0, k != 2'h0}, {31'h0, respFault});
    check(k == 2'h1 ? de : de | 32'h20, u_mem_model.mem[da[31:2]]);
    if (k == 2'h0)
    begin
      check({te[31:12], a[11:0]}, respPhysAddr);
      check(te | 32'h20 | {25'h0, w, 6'h0}, u_mem_model.mem[ta[31:2]]);
      translate({a[31:12], ~a[11:0]}, w, u);
      check({te[31:12], ~a[11:0]}, respPhysAddr);
    end
    else
    begin
      check({16'h0, 13'h0, u, w, k == 2'h3}, {16'h0, respErrCode});
      check(te, u_mem_model.mem[ta[31:2]]);
      read_cr(CR_SEL_FAULT_ADDR, v);
      check(a, v);
    end
  endtask : run_walk

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    check(32'h1, {31'h0, reqReady});
    read_cr(CR_SEL_FAULT_ADDR, v);
    check(FAULT_ADDR_RESET, v);
    read_cr(CR_SEL_DIR_BASE, v);
    check({DIR_BASE_RESET, PAGE_ZERO}, v);
    crWrite = 1'b1;
    crSel = CR_SEL_FAULT_ADDR;
    crWdata = 32'hA5C3_0F96;
    @(negedge clock);
    crWrite = 1'b0;
    read_cr(CR_SEL_FAULT_ADDR, v);
    check(32'hA5C3_0F96, v);
    $display("test reset_and_registers done");
    // Random entries, each present three times in four; the table sits in the frame next to the directory.
    for (int i = 0; i < 40; i++)
    begin
      set_base($random(seed));
      lin = $random(seed);
      r = $random(seed);
      d = $random(seed);
      t = $random(seed);
      d[31:12] = base[31:12] ^ 20'h00001;
      d[0] = r[0] | r[1];
      t[0] = r[2] | r[3];
      d[5] = r[4];
      t[6:5] = r[6:5];
      run_walk(lin, d, t, r[7], r[8]);
    end
    $display("test random_walks done");
    // A dir base rewrite and a task switch both drop the cached entry.
    set_base(32'h0012_3FFF);
    d = 32'h0045_6007;
    run_walk(32'h0804_8123, d, 32'h0ABC_D007, 1'b0, 1'b1);
    set_base(32'h0012_3000);
    run_walk(32'h0804_8123, d, 32'h0FED_C007, 1'b0, 1'b1);
    taskSwitch = 1'b1;
    taskDirBase = 32'h0077_7000;
    @(negedge clock);
    taskSwitch = 1'b0;
    base = 32'h0077_7000;
    run_walk(32'h0804_8123, d, 32'h0135_7007, 1'b0, 1'b1);
    $display("test flush done");
    check(32'h0, 32'(u_mem_model.badWrites));
    check(32'h0, 32'(u_mem_model.misaligned));
    $display("test bus_rules done");
    finish_test();
  end
endmodule : tb_top
